// File: tra_align_top.sv
// Receive alignment, recovered word clocks and test control of a
// ten-bit serial link, with an AHB-Lite register slave.
// Assumes the link clock and serial input are asynchronous pins, much
// slower than I_REF_CLK, and the transmit word comes from local logic.

// Behaviour
// - Receive word bit 0 holds the earliest received bit.
// - Half rate: each word valid at a rising edge, clocks alternate.
// - Half rate: clock A takes words 1 and 3, clock B words 0 and 2.
// - Realignment only stretches clock periods, never shortens them.
// - Normal rate: only clock A runs, one edge per word.
// - Rate select low gives half-rate clocks; high gives A, B low.
// - With align on, comma 0011111 realigns the word boundary.
// - With align off, words pass unframed, no boundary change.
// - Sync output pulses high on a comma, only with align on.
// - In pattern test the sync output shows pass high, fail low.
// - Pattern test enables both generator and checker.
// - Loopback feeds transmit to receive and floats serial outputs.
// - Enable low floats word, clocks, serial outputs and pulls.
// - Rate, loopback, test default low; align and enable high.
// - Pattern test replaces the transmit word with the pattern.
// - Align high latches a pattern failure; low follows the check.
// - Transmit word is captured on the reference clock, bit 0 first.
module tra_align_top
    import tra_pkg::*;
(
    input wire logic I_REF_CLK,
    input wire logic I_RST,
    input wire logic I_CE,
    input wire logic I_HSEL,
    input wire logic [31:0] I_HADDR,
    input wire logic [1:0] I_HTRANS,
    input wire logic I_HWRITE,
    input wire logic [2:0] I_HSIZE,
    input wire logic [31:0] I_HWDATA,
    input wire logic I_HREADY,
    output logic [31:0] O_HRDATA,
    output logic O_HREADYOUT,
    output logic O_HRESP,
    input wire logic I_LINK_CLK,
    input wire logic I_SERIAL_IN,
    input wire logic [9:0] I_TX_WORD,
    output logic [9:0] O_RX_WORD,
    output logic O_RX_CLK_A,
    output logic O_RX_CLK_B,
    output logic O_RX_OE_N,
    output logic O_SYNC_PASS,
    output logic O_SERIAL_OUT_POS,
    output logic O_SERIAL_OUT_NEG,
    output logic O_SERIAL_OE_N,
    output logic O_PULL_EN
);
`include "tra_defines.svh"

    // ------------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------------
    // One-hot select: bit 0 control, bit 1 status, bit 2 receive word
    function automatic logic [2:0] reg_sel(input logic [7:0] ofs);
        reg_sel = {ofs == `TRA_OFS_RXWORD, ofs == `TRA_OFS_STATUS,
                   ofs == `TRA_OFS_CTRL};
    endfunction : reg_sel

    logic [`TRA_CTRL_W-1:0] ctrl_q;
    logic wr_pend_q;
    logic [7:0] wr_ofs_q;
    logic [31:0] hrdata_q;
    logic hreadyout_q;
    logic hresp_q;
    wire addr_ok;
    wire wr_hit;
    wire [`TRA_CTRL_W-1:0] ctrl_d;
    wire [2:0] rd_sel;
    wire [31:0] rd_data;
    wire rate_q;
    wire align_q;
    wire loop_q;
    wire pat_q;
    wire en_q;

    // Write data lands in the data phase; a read right behind it sees it
    assign addr_ok = I_HSEL & I_HTRANS[1] & I_HREADY;
    assign wr_hit = wr_pend_q & (|(reg_sel(wr_ofs_q) & 3'h1));
    assign ctrl_d = wr_hit ? I_HWDATA[`TRA_CTRL_W-1:0] : ctrl_q;
    assign rd_sel = reg_sel(I_HADDR[7:0]);
    assign rate_q = ctrl_q[`TRA_BIT_RATE];
    assign align_q = ctrl_q[`TRA_BIT_ALIGN];
    assign loop_q = ctrl_q[`TRA_BIT_LOOP];
    assign pat_q = ctrl_q[`TRA_BIT_PAT];
    assign en_q = ctrl_q[`TRA_BIT_EN];

    // Bus slave state; always zero wait, always OKAY
    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            ctrl_q <= `TRA_CTRL_RST;
            wr_pend_q <= 1'b0;
            wr_ofs_q <= 8'h00;
            hrdata_q <= 32'h0000_0000;
            hreadyout_q <= 1'b1;
            hresp_q <= 1'b0;
        end else if (I_CE) begin
            ctrl_q <= ctrl_d;
            wr_pend_q <= addr_ok & I_HWRITE;
            wr_ofs_q <= I_HADDR[7:0];
            if (addr_ok && !I_HWRITE) begin
                hrdata_q <= rd_data;
            end
        end
    end

    // ------------------------------------------------------------------
    // Link pin synchronisers and bit tick
    // ------------------------------------------------------------------
    logic [1:0] lclk_s_q;
    logic [1:0] sin_s_q;
    logic lclk_d1_q;
    wire tick;

    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            lclk_s_q <= 2'h0;
            sin_s_q <= 2'h0;
            lclk_d1_q <= 1'b0;
        end else if (I_CE) begin
            lclk_s_q <= {lclk_s_q[0], I_LINK_CLK};
            sin_s_q <= {sin_s_q[0], I_SERIAL_IN};
            lclk_d1_q <= lclk_s_q[1];
        end
    end

    // A disabled device sees no bits at all
    assign tick = lclk_s_q[1] & ~lclk_d1_q & en_q;

    // ------------------------------------------------------------------
    // Transmit serializer and pattern engine
    // ------------------------------------------------------------------
    tra_prbs_if pif ();
    tra_word_t tx_sh_q;
    logic [3:0] tx_cnt_q;
    logic ser_q;
    logic ser_n_q;
    logic ser_oe_n_q;
    wire tx_load;
    wire [9:0] tx_sh_d;
    wire tx_bit;
    wire rx_bit;

    assign tx_load = tx_cnt_q == `TRA_LAST_BIT;
    assign tx_sh_d = tx_load ? I_TX_WORD : {1'b0, tx_sh_q[9:1]};
    assign tx_bit = pat_q ? pif.gen_bit : tx_sh_d[0];
    assign rx_bit = loop_q ? tx_bit : sin_s_q[1];
    assign pif.tick = tick;
    assign pif.gen_en = pat_q;
    assign pif.chk_en = pat_q;
    assign pif.rx_bit = rx_bit;

    tra_prbs u_prbs (
        .i_clk(I_REF_CLK),
        .i_rst(I_RST),
        .i_ce(I_CE),
        .p(pif.prbs)
    );

    // Word is taken every tenth bit tick and sent lowest bit first
    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            tx_sh_q <= 10'h000;
            tx_cnt_q <= `TRA_LAST_BIT;
            ser_q <= 1'b0;
            ser_n_q <= 1'b1;
        end else if (I_CE && tick) begin
            tx_sh_q <= tx_sh_d;
            tx_cnt_q <= tx_load ? 4'h0 : tx_cnt_q + 4'h1;
            ser_q <= tx_bit;
            ser_n_q <= ~tx_bit;
        end
    end

    // ------------------------------------------------------------------
    // Receive deserializer and comma search
    // ------------------------------------------------------------------
    tra_word_t hist_q;
    logic [3:0] rx_cnt_q;
    tra_sync_e sync_st_q;
    wire [9:0] hist_d;
    wire comma_hit;
    wire emit;
    wire [3:0] cnt_inc;

    // Newest bit enters at the top, so bit 0 is the earliest
    assign hist_d = {rx_bit, hist_q[9:1]};
    // Checked on every bit, so every offset is covered
    assign comma_hit = align_q & (hist_d[9:3] == `TRA_COMMA);
    assign emit = tick & (rx_cnt_q == `TRA_LAST_BIT);
    assign cnt_inc = (rx_cnt_q == `TRA_LAST_BIT) ? 4'h0 : rx_cnt_q + 4'h1;

    // Boundary counter only reloads on a comma; free-running otherwise
    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            hist_q <= 10'h000;
            rx_cnt_q <= 4'h0;
        end else if (I_CE && tick) begin
            hist_q <= hist_d;
            rx_cnt_q <= comma_hit ? `TRA_COMMA_CNT : cnt_inc;
        end
    end

    // Lock state for software: hunt until the first comma
    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            sync_st_q <= SYNC_HUNT;
        end else if (I_CE) begin
            case (sync_st_q)
                SYNC_HUNT: begin
                    if (tick && comma_hit) begin
                        sync_st_q <= SYNC_LOCK;
                    end
                end
                SYNC_LOCK: begin
                    if (!align_q) begin
                        sync_st_q <= SYNC_HUNT;
                    end
                end
                default: begin
                    sync_st_q <= SYNC_HUNT;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Recovered word clocks
    // ------------------------------------------------------------------
    // Words wait in a one-deep slot until the clock has had at least a
    // full word time since its last edge; realignment thus only stretches
    tra_word_t pend_word_q;
    tra_word_t rx_word_q;
    logic pend_q;
    logic [3:0] ph_q;
    logic parity_q;
    logic clk_a_q;
    logic clk_b_q;
    logic rx_oe_n_q;
    wire upd;
    wire [9:0] word_sel;

    assign upd = tick & (emit | pend_q) & (ph_q >= `TRA_MIN_GAP);
    assign word_sel = emit ? hist_d : pend_word_q;

    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            pend_q <= 1'b0;
            pend_word_q <= 10'h000;
            ph_q <= `TRA_PH_MAX;
            rx_word_q <= 10'h000;
        end else if (I_CE) begin
            if (emit && !upd) begin
                pend_q <= 1'b1;
                pend_word_q <= hist_d;
            end else if (upd) begin
                pend_q <= 1'b0;
            end
            if (upd) begin
                ph_q <= 4'h0;
                rx_word_q <= word_sel;
            end else if (tick && ph_q != `TRA_PH_MAX) begin
                ph_q <= ph_q + 4'h1;
            end
        end
    end

    // Half rate: even words on B, odd on A; normal rate: A only
    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            parity_q <= 1'b0;
            clk_a_q <= 1'b0;
            clk_b_q <= 1'b0;
        end else if (I_CE) begin
            if (upd) begin
                parity_q <= ~parity_q;
            end
            if (rate_q) begin
                clk_b_q <= 1'b0;
                if (upd) begin
                    clk_a_q <= 1'b1;
                end else if (tick && ph_q == `TRA_NORM_FALL) begin
                    clk_a_q <= 1'b0;
                end
            end else if (upd) begin
                clk_a_q <= parity_q;
                clk_b_q <= ~parity_q;
            end
        end
    end

    // ------------------------------------------------------------------
    // Sync / pass output and pin drive enables
    // ------------------------------------------------------------------
    logic pass_q;
    logic sync_q;
    logic pass_d;

    // Pass follows the checker, or holds low once failed in latched mode
    always_comb begin
        pass_d = pass_q;
        if (!pat_q) begin
            pass_d = 1'b1;
        end else if (tick && pif.chk_ready) begin
            if (pif.err) begin
                pass_d = 1'b0;
            end else if (!align_q) begin
                pass_d = 1'b1;
            end
        end
    end

    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            pass_q <= 1'b1;
            sync_q <= 1'b0;
            rx_oe_n_q <= 1'b0;
            ser_oe_n_q <= 1'b0;
        end else if (I_CE) begin
            pass_q <= pass_d;
            sync_q <= pat_q ? pass_d : (tick & comma_hit);
            rx_oe_n_q <= ~en_q;
            ser_oe_n_q <= ~en_q | loop_q;
        end
    end

    assign rd_data = ({32{rd_sel[0]}} & {27'h000_0000, ctrl_d})
        | ({32{rd_sel[1]}} & {29'h0000_0000, sync_st_q == SYNC_LOCK, pass_q, sync_q})
        | ({32{rd_sel[2]}} & {22'h00_0000, rx_word_q});

    assign O_HRDATA = hrdata_q;
    assign O_HREADYOUT = hreadyout_q;
    assign O_HRESP = hresp_q;
    assign O_RX_WORD = rx_word_q;
    assign O_RX_CLK_A = clk_a_q;
    assign O_RX_CLK_B = clk_b_q;
    assign O_RX_OE_N = rx_oe_n_q;
    assign O_SYNC_PASS = sync_q;
    assign O_SERIAL_OUT_POS = ser_q;
    assign O_SERIAL_OUT_NEG = ser_n_q;
    assign O_SERIAL_OE_N = ser_oe_n_q;
    assign O_PULL_EN = ctrl_q[`TRA_BIT_EN];

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge I_REF_CLK); endclocking
    default disable iff (I_RST);

    clk_b_low_a: assert property (
        I_CE && rate_q |=> !clk_b_q)
        else $error("clock B not low in normal rate");
    half_clk_alt_a: assert property (
        I_CE && upd && !rate_q |=> (clk_a_q != clk_b_q) && (clk_a_q == $past(parity_q)))
        else $error("half-rate clocks not alternating");
    no_short_clk_a: assert property (
        $rose(clk_a_q) && $past(rate_q) |-> $past(ph_q) >= `TRA_MIN_GAP)
        else $error("clock period shortened");
    sync_needs_align_a: assert property (
        I_CE && !pat_q && !align_q |=> !sync_q)
        else $error("sync pulse without align");
    comma_pulse_a: assert property (
        I_CE && tick && comma_hit && !pat_q |=> sync_q ##1 (!I_CE || !tick || sync_q == comma_hit))
        else $error("comma not reported");
    loop_float_a: assert property (
        I_CE && loop_q |=> O_SERIAL_OE_N)
        else $error("serial outputs driven in loopback");
    disable_float_a: assert property (
        I_CE && !en_q |-> !tick ##1 (O_RX_OE_N && O_SERIAL_OE_N))
        else $error("outputs driven while disabled");
    fail_latched_a: assert property (
        (I_CE && pat_q && align_q && !pass_q) ##1 (pat_q && align_q) |-> !pass_q)
        else $error("latched failure released");
    pattern_tx_a: assert property (
        I_CE && tick && pat_q |=> O_SERIAL_OUT_POS == $past(pif.gen_bit))
        else $error("pattern not transmitted");

    half_word_c: cover property (I_CE && upd && !rate_q && parity_q);
    realign_c: cover property (I_CE && tick && comma_hit && cnt_inc != `TRA_COMMA_CNT);
    stretch_c: cover property (I_CE && emit && !upd);
    fail_c: cover property (pat_q && align_q && !pass_q);

endmodule : tra_align_top

// File: tra_defines.svh
// Offsets, field positions, reset values and timing counts of the
// receive-align and test-control block.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef TRA_DEFINES_SVH
`define TRA_DEFINES_SVH

// ----------------------------------------------------------------------
// Register byte offsets (decoded on haddr[7:0])
// ----------------------------------------------------------------------
`define TRA_OFS_CTRL 8'h00
`define TRA_OFS_STATUS 8'h04
`define TRA_OFS_RXWORD 8'h08

// ----------------------------------------------------------------------
// Control register fields and reset value
// ----------------------------------------------------------------------
`define TRA_CTRL_W 5
`define TRA_BIT_RATE 0
`define TRA_BIT_ALIGN 1
`define TRA_BIT_LOOP 2
`define TRA_BIT_PAT 3
`define TRA_BIT_EN 4
// Align and enable default high, the rest low
`define TRA_CTRL_RST 5'h12

// ----------------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------------
`define TRA_ST_SYNC 0
`define TRA_ST_PASS 1
`define TRA_ST_LOCK 2

// ----------------------------------------------------------------------
// Line coding and timing counts, in received bits
// ----------------------------------------------------------------------
`define TRA_COMMA 7'h7C
`define TRA_COMMA_CNT 4'h7
`define TRA_LAST_BIT 4'h9
`define TRA_MIN_GAP 4'h9
`define TRA_NORM_FALL 4'h4
`define TRA_PH_MAX 4'hF
`define TRA_PRBS_WARM 3'h7
`define TRA_PRBS_SEED 7'h7F

`endif

// File: tra_pkg.sv
// Types shared by the receive-align block and its pattern engine.
// Assumes nothing beyond a SystemVerilog compiler.
package tra_pkg;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef logic [9:0] tra_word_t;

    // Word-boundary search state, one-hot
    typedef enum logic [1:0] {
        SYNC_HUNT = 2'h1,
        SYNC_LOCK = 2'h2
    } tra_sync_e;

endpackage : tra_pkg

// File: tra_prbs_if.sv
// Carrier between the align core and the pattern engine.
// Assumes both ends run on the same clock.
interface tra_prbs_if;
    logic tick;
    logic gen_en;
    logic chk_en;
    logic rx_bit;
    logic gen_bit;
    logic err;
    logic chk_ready;

    modport core (output tick, output gen_en, output chk_en, output rx_bit,
                  input gen_bit, input err, input chk_ready);
    modport prbs (input tick, input gen_en, input chk_en, input rx_bit,
                  output gen_bit, output err, output chk_ready);
endinterface : tra_prbs_if

// File: tra_prbs.sv
// Seven-stage pattern generator and self-synchronising checker.
// Assumes tick is a one-cycle pulse per serial bit from the core.
module tra_prbs
    import tra_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    tra_prbs_if.prbs p
);
`include "tra_defines.svh"

    logic [6:0] gen_q;
    logic [6:0] chk_q;
    logic [2:0] warm_q;
    wire gen_fb;
    wire chk_pred;

    // ------------------------------------------------------------------
    // Feedback taps x^7 + x^6 + 1
    // ------------------------------------------------------------------
    assign gen_fb = gen_q[6] ^ gen_q[5];
    assign chk_pred = chk_q[6] ^ chk_q[5];
    assign p.gen_bit = gen_fb;
    assign p.err = chk_pred != p.rx_bit;
    assign p.chk_ready = warm_q == `TRA_PRBS_WARM;

    // Generator restarts from a non-zero seed whenever the test is off
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            gen_q <= `TRA_PRBS_SEED;
        end else if (i_ce) begin
            if (!p.gen_en) begin
                gen_q <= `TRA_PRBS_SEED;
            end else if (p.tick) begin
                gen_q <= {gen_q[5:0], gen_fb};
            end
        end
    end

    // Checker loads received bits; verdicts only count after seven bits
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            chk_q <= 7'h00;
            warm_q <= 3'h0;
        end else if (i_ce) begin
            if (!p.chk_en) begin
                chk_q <= 7'h00;
                warm_q <= 3'h0;
            end else if (p.tick) begin
                chk_q <= {chk_q[5:0], p.rx_bit};
                if (warm_q != `TRA_PRBS_WARM) begin
                    warm_q <= warm_q + 3'h1;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    gen_nonzero_a: assert property (
        @(posedge i_clk) disable iff (i_rst) p.gen_en |-> gen_q != 7'h00)
        else $error("pattern generator stuck at zero");

endmodule : tra_prbs

// File: tra_link_peer.sv
// Behavioural far end of the serial link: bit clock and serial data.
// Assumes the receiver samples data at the rising edge of the bit clock.
module tra_link_peer (
    output logic o_link_clk,
    output logic o_ser
);
    timeunit 1ns;
    timeprecision 100ps;

    // ------------------------------------------------------------------
    // Line idle state
    // ------------------------------------------------------------------
    initial begin
        o_link_clk = 1'b0;
        o_ser = 1'b0;
    end

    // Send n bits, earliest in bit 0; clock stands still between frames
    task automatic send_bits(input logic [39:0] b, input int n);
        // Stay clear of the reference clock edges so pins never race it
        #5;
        for (int i = 0; i < n; i++) begin
            o_ser = b[i];
            #100 o_link_clk = 1'b1;
            #100 o_link_clk = 1'b0;
        end
        // No pull on the line: invert so a stale bit cannot pass as data
        o_ser = ~o_ser;
    endtask : send_bits
endmodule : tra_link_peer

// File: tb_top.sv
// Self-checking bench for the receive-align and test-control block.
// Assumes the AHB slave answers with zero wait states and one peer.
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    // ------------------------------------------------------------------
    // Stimulus and observed signals
    // ------------------------------------------------------------------
    typedef struct {logic w; logic [7:0] a; logic [31:0] d;} tra_row_s;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [9:0] tx_word = 10'h17C; // Comma-led word from the protocol side
    logic [31:0] hrdata, rd;
    logic hreadyout, hresp, lclk, ser, rx_oe_n, sync, sop, son, soe_n, pull_en, clka, clkb;
    logic [9:0] rx_word;
    logic seen;
    int na, nb, ns, miscompares = 0, n_compared = 0;
    // Comma 0011111 after alternating filler, word closes 3 bits later
    logic [39:0] pat = {18'h2_AAAA, 3'b010, 7'b111_1100, 12'hAAA};
    tra_row_s rows [6] = '{
        '{1'b0, 8'h00, 32'h0000_0012}, '{1'b1, 8'h00, 32'h0000_0013},
        '{1'b0, 8'h00, 32'h0000_0013}, '{1'b1, 8'h08, 32'h0000_03FF},
        '{1'b0, 8'h08, 32'h0000_0000}, '{1'b0, 8'h0C, 32'h0000_0000}};

    always #12.5 clk = ~clk;

    tra_link_peer tra_link_peer_i (.o_link_clk(lclk), .o_ser(ser));

    tra_align_top tra_align_top_i (
        .I_REF_CLK(clk), .I_RST(rst), .I_CE(ce), .I_HSEL(hsel), .I_HADDR(haddr),
        .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HWDATA(hwdata),
        .I_HREADY(hreadyout), .O_HRDATA(hrdata), .O_HREADYOUT(hreadyout),
        .O_HRESP(hresp), .I_LINK_CLK(lclk), .I_SERIAL_IN(ser), .I_TX_WORD(tx_word),
        .O_RX_WORD(rx_word), .O_RX_CLK_A(clka), .O_RX_CLK_B(clkb), .O_RX_OE_N(rx_oe_n),
        .O_SYNC_PASS(sync), .O_SERIAL_OUT_POS(sop), .O_SERIAL_OUT_NEG(son),
        .O_SERIAL_OE_N(soe_n), .O_PULL_EN(pull_en));

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic check(input logic [31:0] seen_v, input logic [31:0] exp_v);
        n_compared++;
        if (seen_v !== exp_v) begin
            miscompares++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen_v, exp_v);
        end
    endtask : check

    // One single AHB transfer; waits on hready in both phases
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h00_0000, a};
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : ahb

    // Send bits from the peer while counting clock rises and sync pulses
    task automatic run(input logic [39:0] b, input int n, input logic [9:0] want);
        logic pa, pb, ps;
        na = 0;
        nb = 0;
        ns = 0;
        seen = 1'b0;
        pa = clka;
        pb = clkb;
        ps = sync;
        fork
            tra_link_peer_i.send_bits(b, n);
            repeat (n * 8 + 40) begin
                @(posedge clk);
                na += int'(clka === 1'b1 && pa === 1'b0);
                nb += int'(clkb === 1'b1 && pb === 1'b0);
                ns += int'(sync === 1'b1 && ps === 1'b0);
                seen |= (rx_word === want);
                pa = clka;
                pb = clkb;
                ps = sync;
            end
        join
    endtask : run

    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : print_verdict

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        check({hreadyout, hresp, sync, sop, son, soe_n, pull_en, rx_oe_n}, 8'h8A);
        check({rx_word, clka, clkb}, 12'h000);
        // Register table rows, including read-only and unmapped places
        foreach (rows[i]) begin
            ahb(rows[i].w, rows[i].a, rows[i].d);
            if (!rows[i].w) check(rd, rows[i].d);
        end
        // Normal rate with alignment: one comma, one framed word
        run(pat, 40, 10'h17C);
        check(ns, 1);
        check(seen, 1'b1);
        check(nb, 0);
        check(na, 3);
        ahb(1'b0, 8'h04, 32'h0000_0000);
        check(rd[2], 1'b1);
        // Half rate: both clocks run, words alternate between them
        ahb(1'b1, 8'h00, 32'h0000_0012);
        run(pat, 40, 10'h17C);
        check(int'(na >= 1 && nb >= 1 && na - nb <= 1 && nb - na <= 1), 1);
        check({seen, 31'(ns)}, {1'b1, 31'h0000_0001});
        // Alignment off: a comma off the old boundary is neither reported nor framed
        ahb(1'b1, 8'h00, 32'h0000_0011);
        run(pat >> 5, 40, 10'h17C);
        check(ns, 0);
        check(seen, 1'b0);
        // Pattern test through loopback passes and floats the serial pair
        ahb(1'b1, 8'h00, 32'h0000_001C);
        run(40'h00_0000_0000, 40, 10'h000);
        check({sync, soe_n}, 2'h3);
        // External all-ones stream fails the check; loopback off here
        ahb(1'b1, 8'h00, 32'h0000_001A);
        run(40'hFF_FFFF_FFFF, 20, 10'h000);
        check({sync, soe_n}, 2'h0);
        // Align high keeps the failure even with a clean loopback stream
        ahb(1'b1, 8'h00, 32'h0000_001E);
        run(40'h00_0000_0000, 30, 10'h000);
        check(sync, 1'b0);
        // Align low follows the current result again
        ahb(1'b1, 8'h00, 32'h0000_001C);
        run(40'h00_0000_0000, 30, 10'h000);
        check(sync, 1'b1);
        // Plain loopback with alignment: the transmit word comes back framed
        ahb(1'b1, 8'h00, 32'h0000_0016);
        run(40'h00_0000_0000, 40, 10'h17C);
        check(seen, 1'b1);
        check(int'(ns >= 3), 1);
        // Device disabled: outputs float, pulls off, nothing moves
        ahb(1'b1, 8'h00, 32'h0000_0000);
        repeat (4) @(posedge clk);
        check({rx_oe_n, soe_n, pull_en}, 3'h6);
        run(pat, 20, 10'h000);
        check(na + nb, 0);
        // Second reset in mid-run restores the control defaults
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        ahb(1'b0, 8'h00, 32'h0000_0000);
        check(rd, 32'h0000_0012);
        // Clock enable low: a write is lost and the defaults stay
        ce <= 1'b0;
        ahb(1'b1, 8'h00, 32'h0000_0000);
        ce <= 1'b1;
        ahb(1'b0, 8'h00, 32'h0000_0000);
        check(rd, 32'h0000_0012);
        print_verdict();
    end

    // Watchdog well beyond the roughly 70 us the sequence needs
    initial begin
        #500000;
        miscompares++;
        print_verdict();
    end
endmodule : tb_top
